//--- logic/ndr_readback.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ndr_readback (
  input  wire logic                                         MCLK,
  input  wire logic                                         SRST,
  input  wire logic                                         SYNTH_PATH_ENABLE,
  input  wire logic [ndr_pkg::N_CHAN*ndr_pkg::AMP_W-1:0]    CHAN_AMPLITUDE_LIVE,
  input  wire logic [ndr_pkg::N_OSC*ndr_pkg::FREQ_W-1:0]    OSC_FREQUENCY_LIVE,
  input  wire logic [ndr_pkg::N_PHASE*ndr_pkg::PHASE_W-1:0] OSC_PHASE_LIVE,
  input  wire logic [ndr_pkg::ADDR_W-1:0]                   AWADDR,
  input  wire logic [2:0]                                   AWPROT,
  input  wire logic                                         AWVALID,
  output logic                                              AWREADY,
  input  wire logic [31:0]                                  WDATA,
  input  wire logic [3:0]                                   WSTRB,
  input  wire logic                                         WVALID,
  output logic                                              WREADY,
  output logic [1:0]                                        BRESP,
  output logic                                              BVALID,
  input  wire logic                                         BREADY,
  input  wire logic [ndr_pkg::ADDR_W-1:0]                   ARADDR,
  input  wire logic [2:0]                                   ARPROT,
  input  wire logic                                         ARVALID,
  output logic                                              ARREADY,
  output logic [31:0]                                       RDATA,
  output logic [1:0]                                        RRESP,
  output logic                                              RVALID,
  input  wire logic                                         RREADY
);
  import ndr_pkg::*;

  logic             awready_r;
  logic             wready_r;
  logic             aw_got_r;
  logic             w_got_r;
  logic [IDX_W-1:0] aw_idx_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             arready_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic [7:0]       pick_byte;
  logic             pick_hit;
  logic [IDX_W-1:0] ar_idx;

  assign AWREADY = awready_r;
  assign WREADY  = wready_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;
  assign ar_idx  = ARADDR[ADDR_W-1:2];

  // write address channel; one write in flight at a time
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b0;
      aw_idx_r  <= '0;
    end else if (AWVALID && awready_r) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b1;
      aw_idx_r  <= AWADDR[ADDR_W-1:2];
    end else if (aw_got_r && w_got_r && !bvalid_r) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  // write data channel; data is dropped since every register is read-only
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else if (WVALID && wready_r) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b1;
    end else if (aw_got_r && w_got_r && !bvalid_r) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // write response: okay on a readback slot, decode error elsewhere
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (aw_got_r && w_got_r && !bvalid_r) begin
      bvalid_r <= 1'b1;
      bresp_r  <= ndr_is_mapped(aw_idx_r) ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  ndr_byte_pick u_pick (
    .idx     (ar_idx),
    .path_en (SYNTH_PATH_ENABLE),
    .amp     (CHAN_AMPLITUDE_LIVE),
    .freq    (OSC_FREQUENCY_LIVE),
    .phase   (OSC_PHASE_LIVE),
    .byte_val (pick_byte),
    .hit     (pick_hit)
  );

  // read channel: each byte is caught at its own address handshake, no
  // wide latch, so a value moving between byte reads may come back torn
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= RDATA_RST;
      rresp_r   <= RESP_OKAY;
    end else if (ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, pick_byte};
      rresp_r   <= pick_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  logic rd_hs;
  logic wr_hs_aw;
  assign rd_hs    = ARVALID && arready_r;
  assign wr_hs_aw = AWVALID && awready_r;

  a_amp_ch0_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP0_IDX && SYNTH_PATH_ENABLE
    |=> RVALID && RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[7:0]))
    else $error("amplitude channel 0 low byte wrong");

  a_amp_disabled: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx >= AMP0_IDX && ar_idx <= AMP3_IDX + 10'h001 && !SYNTH_PATH_ENABLE
    |=> RDATA == 32'h0000_0000 && RRESP == RESP_OKAY)
    else $error("amplitude read with path off not zero");

  a_amp_ch1_high: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP1_IDX + 10'h001 && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[31:24]))
    else $error("amplitude channel 1 high byte wrong");

  a_amp_ch3_high: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP3_IDX + 10'h001 && SYNTH_PATH_ENABLE
    |=> RDATA == {24'h00_0000, $past(CHAN_AMPLITUDE_LIVE[63:56])})
    else $error("amplitude channel 3 high byte not sampled at read");

  a_freq_osc1_top: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ1_IDX + 10'h007
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[127:120]))
    else $error("oscillator 1 frequency top byte wrong");

  a_phase_osc1_hi: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE1_IDX + 10'h001
    |=> RDATA[7:0] == $past(OSC_PHASE_LIVE[31:24]) && RRESP == RESP_OKAY)
    else $error("oscillator 1 phase high byte wrong");

  a_read_held: assert property (@(posedge MCLK) disable iff (SRST)
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && !ARREADY)
    else $error("read answer changed before taken");

  a_freq_osc3_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ3_IDX |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[199:192]))
    else $error("oscillator 3 frequency low byte wrong");

  a_write_ignored: assert property (@(posedge MCLK) disable iff (SRST)
    wr_hs_aw && ndr_is_mapped(AWADDR[ADDR_W-1:2]) && WVALID && WREADY
    |=> ##[1:2] BVALID && BRESP == RESP_OKAY)
    else $error("write to readback slot not answered okay");

  a_unmapped_read: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && !ndr_is_mapped(ar_idx) |=> RRESP == RESP_DECERR && RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  a_one_write: assert property (@(posedge MCLK) disable iff (SRST)
    BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");

  a_amp_ch0_high: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP0_IDX + 10'h001 && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[15:8]))
    else $error("amplitude channel 0 high byte wrong");

  a_amp_ch1_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP1_IDX && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[23:16]))
    else $error("amplitude channel 1 low byte wrong");

  a_amp_ch2_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP2_IDX && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[39:32]))
    else $error("amplitude channel 2 low byte wrong");

  a_amp_ch2_high: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP2_IDX + 10'h001 && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[47:40]))
    else $error("amplitude channel 2 high byte wrong");

  a_amp_ch3_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP3_IDX && SYNTH_PATH_ENABLE
    |=> RDATA[7:0] == $past(CHAN_AMPLITUDE_LIVE[55:48]))
    else $error("amplitude channel 3 low byte wrong");

  a_freq_osc0_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ0_IDX
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[7:0]))
    else $error("oscillator 0 frequency low byte wrong");

  a_freq_osc0_top: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ0_IDX + 10'h007
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[63:56]))
    else $error("oscillator 0 frequency top byte wrong");

  a_freq_osc1_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ1_IDX
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[71:64]))
    else $error("oscillator 1 frequency low byte wrong");

  a_freq_osc2_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ2_IDX
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[135:128]))
    else $error("oscillator 2 frequency low byte wrong");

  a_freq_osc2_top: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ2_IDX + 10'h007
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[191:184]))
    else $error("oscillator 2 frequency top byte wrong");

  a_freq_osc3_top: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ3_IDX + 10'h007
    |=> RDATA[7:0] == $past(OSC_FREQUENCY_LIVE[255:248]))
    else $error("oscillator 3 frequency top byte wrong");

  a_phase_osc0_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE0_IDX
    |=> RDATA[7:0] == $past(OSC_PHASE_LIVE[7:0]) && RRESP == RESP_OKAY)
    else $error("oscillator 0 phase low byte wrong");

  a_phase_osc0_hi: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE0_IDX + 10'h001
    |=> RDATA[7:0] == $past(OSC_PHASE_LIVE[15:8]))
    else $error("oscillator 0 phase high byte wrong");

  a_phase_osc1_low: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE1_IDX
    |=> RDATA[7:0] == $past(OSC_PHASE_LIVE[23:16]))
    else $error("oscillator 1 phase low byte wrong");

  a_phase_osc2_absent: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE1_IDX + 10'h002
    |=> RRESP == RESP_DECERR && RDATA == 32'h0000_0000)
    else $error("slot past oscillator 1 phase not refused");

  a_read_answer: assert property (@(posedge MCLK) disable iff (SRST)
    rd_hs |=> RVALID && !ARREADY)
    else $error("read not answered one cycle after address");

  a_read_one_byte: assert property (@(posedge MCLK) disable iff (SRST)
    RVALID |-> RDATA[31:8] == 24'h00_0000)
    else $error("read data above one byte not zero");

  a_read_excl: assert property (@(posedge MCLK) disable iff (SRST)
    RVALID |-> !ARREADY)
    else $error("read address taken while answer pending");

  a_read_release: assert property (@(posedge MCLK) disable iff (SRST)
    RVALID && RREADY |=> !RVALID)
    else $error("read answer stayed after being taken");

  a_write_held: assert property (@(posedge MCLK) disable iff (SRST)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer changed before taken");

  a_write_unmapped: assert property (@(posedge MCLK) disable iff (SRST)
    wr_hs_aw && !ndr_is_mapped(AWADDR[ADDR_W-1:2]) && WVALID && WREADY
    |=> ##[1:2] BVALID && BRESP == RESP_DECERR)
    else $error("write outside readback slots not refused");

  a_write_release: assert property (@(posedge MCLK) disable iff (SRST)
    BVALID && BREADY |=> !BVALID)
    else $error("write answer stayed after being taken");

  a_reset_quiet: assert property (@(posedge MCLK)
    SRST |=> !RVALID && !BVALID && !ARREADY && !AWREADY && !WREADY
    && RDATA == 32'h0000_0000)
    else $error("bus outputs not quiet after reset");

  c_amp_read:   cover property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == AMP2_IDX && SYNTH_PATH_ENABLE ##1 RVALID && RREADY);
  c_freq_read:  cover property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == FREQ2_IDX);
  c_phase_read: cover property (@(posedge MCLK) disable iff (SRST)
    rd_hs && ar_idx == PHASE0_IDX);
  c_write_done: cover property (@(posedge MCLK) disable iff (SRST)
    BVALID && BREADY);
  c_read_stall: cover property (@(posedge MCLK) disable iff (SRST)
    RVALID && !RREADY);
endmodule

//--- logic/ndr_pkg.sv
package ndr_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned IDX_W       = 10;
  localparam int unsigned N_CHAN      = 4;
  localparam int unsigned N_OSC       = 4;
  localparam int unsigned N_PHASE     = 2;
  localparam int unsigned AMP_W       = 16;
  localparam int unsigned FREQ_W      = 64;
  localparam int unsigned PHASE_W     = 16;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [9:0]  AMP0_IDX    = 10'h378;
  localparam logic [9:0]  AMP1_IDX    = 10'h37a;
  localparam logic [9:0]  AMP2_IDX    = 10'h37c;
  localparam logic [9:0]  AMP3_IDX    = 10'h37e;
  localparam logic [9:0]  FREQ0_IDX   = 10'h380;
  localparam logic [9:0]  FREQ1_IDX   = 10'h388;
  localparam logic [9:0]  FREQ2_IDX   = 10'h390;
  localparam logic [9:0]  FREQ3_IDX   = 10'h398;
  localparam logic [9:0]  PHASE0_IDX  = 10'h3a0;
  localparam logic [9:0]  PHASE1_IDX  = 10'h3a2;
  localparam logic [9:0]  AMP_BYTES   = 10'h008;
  localparam logic [9:0]  FREQ_BYTES  = 10'h020;
  localparam logic [9:0]  PHASE_BYTES = 10'h004;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  function automatic logic ndr_in_range(input logic [9:0] idx, input logic [9:0] base,
                                        input logic [9:0] n);
    ndr_in_range = (idx >= base) && (idx < base + n);
  endfunction

  function automatic logic ndr_is_mapped(input logic [9:0] idx);
    ndr_is_mapped = ndr_in_range(idx, AMP0_IDX, AMP_BYTES) ||
                    ndr_in_range(idx, FREQ0_IDX, FREQ_BYTES) ||
                    ndr_in_range(idx, PHASE0_IDX, PHASE_BYTES);
  endfunction
endpackage

//--- logic/ndr_byte_pick.sv
`timescale 1ns/1ps
module ndr_byte_pick (
  input  wire logic [9:0]   idx,
  input  wire logic         path_en,
  input  wire logic [63:0]  amp,
  input  wire logic [255:0] freq,
  input  wire logic [31:0]  phase,
  output logic [7:0]        byte_val,
  output logic              hit
);
  import ndr_pkg::*;

  logic [9:0] off;

  // pure combinational selection: a read never touches the datapath
  always_comb begin
    off    = 10'h000;
    byte_val = 8'h00;
    hit    = 1'b0;
    if (ndr_in_range(idx, AMP0_IDX, AMP_BYTES)) begin
      off = idx - AMP0_IDX;
      hit = 1'b1;
      // value is meaningless with the path off, so return zero
      byte_val = path_en ? amp[{off[2:0], 3'h0} +: 8] : 8'h00;
    end else if (ndr_in_range(idx, FREQ0_IDX, FREQ_BYTES)) begin
      off    = idx - FREQ0_IDX;
      hit    = 1'b1;
      byte_val = freq[{off[4:0], 3'h0} +: 8];
    end else if (ndr_in_range(idx, PHASE0_IDX, PHASE_BYTES)) begin
      off    = idx - PHASE0_IDX;
      hit    = 1'b1;
      byte_val = phase[{off[1:0], 3'h0} +: 8];
    end
  end
endmodule

//--- verif/tb_nco_dds_operating_readback.sv
`timescale 1ns/1ps
module tb_nco_dds_operating_readback;
  import ndr_pkg::*;
  logic                       mclk = 1'b0;
  logic                       srst = 1'b1;
  logic                       en = 1'b0;
  logic [N_CHAN*AMP_W-1:0]    amp = '0;
  logic [N_OSC*FREQ_W-1:0]    freq = '0;
  logic [N_PHASE*PHASE_W-1:0] phase = '0;
  logic [ADDR_W-1:0]          awaddr = '0;
  logic [ADDR_W-1:0]          araddr = '0;
  logic [31:0]                wdata = '0;
  logic                       awvalid = 1'b0;
  logic                       wvalid = 1'b0;
  logic                       arvalid = 1'b0;
  logic                       rready = 1'b0;
  logic                       bready = 1'b0;
  int                         stall = 0;
  logic                       awready, wready, bvalid, arready, rvalid;
  logic [1:0]                 bresp, rresp;
  logic [31:0]                rdata;
  int                         mismatches = 0;
  int                         comparisons = 0;

  always #12.5 mclk = ~mclk;

  // answer ready lines rise only after stall cycles, so held answers get exercised
  ndr_readback i_dut (.MCLK(mclk), .SRST(srst), .SYNTH_PATH_ENABLE(en),
    .CHAN_AMPLITUDE_LIVE(amp), .OSC_FREQUENCY_LIVE(freq), .OSC_PHASE_LIVE(phase),
    .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] expect_byte(input logic [9:0] i);
    expect_byte = 32'h0;
    if (i >= AMP0_IDX && i < AMP0_IDX + 10'h008 && en)
      expect_byte[7:0] = amp[8*(i-AMP0_IDX) +: 8];
    if (i >= FREQ0_IDX && i < FREQ0_IDX + 10'h020)
      expect_byte[7:0] = freq[8*(i-FREQ0_IDX) +: 8];
    if (i >= PHASE0_IDX && i < PHASE0_IDX + 10'h004)
      expect_byte[7:0] = phase[8*(i-PHASE0_IDX) +: 8];
  endfunction

  function automatic logic [1:0] resp_for(input logic [9:0] i);
    resp_for = (i >= AMP0_IDX && i < PHASE0_IDX + 10'h004) ? RESP_OKAY : RESP_DECERR;
  endfunction

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp_d, input logic [1:0] exp_r);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin @(posedge mclk); n++; end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    repeat (stall) @(posedge mclk);
    rready <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    check({31'h0, rvalid}, 32'h1, "read answer");
    check(rdata, exp_d, "read data");
    check({30'h0, rresp}, {30'h0, exp_r}, "read response");
    @(posedge mclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [1:0] exp_r);
    int   n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= 32'ha5a5_5a5a;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done) && n < 100) begin
      @(posedge mclk);
      n++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    n = 0;
    repeat (stall) @(posedge mclk);
    bready <= 1'b1;
    do begin @(posedge mclk); n++; end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    check({31'h0, bvalid}, 32'h1, "write answer");
    check({30'h0, bresp}, {30'h0, exp_r}, "write response");
    @(posedge mclk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    amp <= 64'h8001_7fff_1234_fedc;
    freq <= {64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210,
             64'h8000_0000_0000_0001, 64'h55aa_33cc_0ff0_a5c3};
    phase <= 32'h8000_7ffe;
    en <= 1'b1;
    @(posedge mclk);
    // whole map, with unmapped neighbours below and above (osc2 phase absent)
    for (int i = 'h374; i < 'h3a8; i++) begin
      rd(10'(i), expect_byte(10'(i)), resp_for(10'(i)));
    end
    en <= 1'b0;
    @(posedge mclk);
    for (int i = 'h378; i < 'h380; i++) begin
      rd(10'(i), 32'h0, RESP_OKAY);
    end
    en <= 1'b1;
    @(posedge mclk);
    rd(10'h37a, expect_byte(10'h37a), RESP_OKAY);
    rd(10'h380, expect_byte(10'h380), RESP_OKAY);
    // value moves between byte reads: upper byte must be the new one
    amp <= ~amp;
    freq <= {freq[127:0], freq[255:128]};
    phase <= ~phase;
    @(posedge mclk);
    rd(10'h37b, expect_byte(10'h37b), RESP_OKAY);
    rd(10'h381, expect_byte(10'h381), RESP_OKAY);
    rd(10'h3a1, expect_byte(10'h3a1), RESP_OKAY);
    // answers held back a few cycles from here on
    stall = 3;
    wr(AMP0_IDX, RESP_OKAY);
    wr(FREQ3_IDX, RESP_OKAY);
    wr(PHASE1_IDX, RESP_OKAY);
    wr(10'h3a4, RESP_DECERR);
    rd(AMP0_IDX, expect_byte(AMP0_IDX), RESP_OKAY);
    rd(FREQ3_IDX, expect_byte(FREQ3_IDX), RESP_OKAY);
    rd(PHASE1_IDX, expect_byte(PHASE1_IDX), RESP_OKAY);
    give_verdict();
  end

  // about 72 transfers of a few cycles each; generous margin
  initial begin
    #(25 * 5000);
    mismatches++;
    give_verdict();
  end
endmodule
